/* include/cam_cfg_pkg.sv */
package cam_cfg_pkg;

  // ==========================================================
  // address map (field bit 0 is the word's lsb)
  // ==========================================================
  localparam logic [19:0] BASE_PAGE = 20'hF0F00;
  localparam logic [11:0] OFS_EEPROM = 12'hF00;
  localparam logic [11:0] OFS_TEST = 12'hF04;
  localparam logic [11:0] OFS_SENSOR = 12'hF08;
  localparam logic [11:0] OFS_SAMPLER = 12'hF0C;
  localparam logic [11:0] OFS_AE = 12'hF10;
  localparam logic [11:0] OFS_DAC = 12'hF14;
  localparam logic [11:0] OFS_OPTICS = 12'hF18;
  localparam logic [11:0] OFS_STATPIN = 12'hF1C;
  localparam logic [11:0] OFS_FRONTEND = 12'hF20;
  localparam logic [11:0] OFS_MOTOR = 12'hF24;
  localparam logic [11:0] OFS_STATUS = 12'hF28;

  // ==========================================================
  // field layouts, masks and reset values
  // ==========================================================
  localparam logic [31:0] UNLOCK_MAGIC = 32'h12345678;
  localparam int TEST_EN_BIT = 31;
  localparam int POS_W = 6;
  localparam int HORIZ_LSB = 16;
  localparam int RGATE_LSB = 8;
  localparam int SGATE_LSB = 0;
  localparam int CONV_LSB = 24;
  localparam int VSMP_LSB = 8;
  localparam int RSMP_LSB = 0;
  localparam int SENSOR_SEL_LSB = 17;
  localparam logic [31:0] MASK_TEST = 32'h80000000;
  localparam logic [31:0] MASK_SENSOR = 32'h003F3F3F;
  localparam logic [31:0] MASK_SAMPLER = 32'h3F003F3F;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [31:0] RST_AE = 32'h02009A80; // two settle frames
  localparam logic [31:0] RST_FRONTEND = 32'h00610000;

  // error bands of the exposure loop, in luminance steps
  localparam logic [7:0] FAR_ERR = 8'h30;
  localparam logic [7:0] MOD_ERR = 8'h08;

  // nominal pulse positions per sensor select, order:
  // horizontal, reset gate, shift gate, converter, video, reference
  localparam logic [5:0] NOMINAL [3][6] = '{
    '{6'h04, 6'h08, 6'h0C, 6'h02, 6'h10, 6'h14},
    '{6'h06, 6'h0A, 6'h0E, 6'h03, 6'h12, 6'h16},
    '{6'h05, 6'h09, 6'h0D, 6'h01, 6'h11, 6'h15}
  };

  // colour bar luminance levels, left to right
  localparam logic [7:0] BAR_LEVEL [8] = '{
    8'hEB, 8'hD2, 8'hAA, 8'h91, 8'h6A, 8'h51, 8'h29, 8'h10
  };

  // ==========================================================
  // types
  // ==========================================================
  typedef struct packed {
    logic [7:0] settle;
    logic [7:0] gain_floor;
    logic [4:0] fast_step;
    logic [2:0] mod_step;
    logic [7:0] luma_target;
  } ae_cfg_t;

  typedef struct packed {
    logic [6:0] horiz_phase_two_pos;
    logic [6:0] reset_gate_pos;
    logic [6:0] shift_gate_phase_one_pos;
    logic [6:0] conv_clk_pos;
    logic [6:0] video_sample_pos;
    logic [6:0] reference_sample_pos;
  } pulse_pos_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] ofs;
  } ahb_req_t;

  typedef enum logic [0:0] {
    AE_SETTLE = 1'b0,
    AE_RUN = 1'b1
  } ae_state_t;

endpackage

/* rtl/camera_config_register_bank.sv */
// Summary of operation
// [R01] registers decode as byte offsets above one fixed base address
// [R02] eeprom unlocked only while unlock word holds the magic pattern
// [R03] colour bar bit replaces sensor video with a colour bar pattern
// [R04] sensor pulse fields are 6 bits, 00h nominal, 3Fh maximum delay
// [R05] sampling pulse fields are 6 bits, 00h nominal, 3Fh maximum delay
// [R06] auto exposure waits the settle field's frame count after start-up
// [R07] saturation gain floor is the least gain the loop may use
// [R08] fast step applies to frames far from target, bigger is faster
// [R09] moderate step applies to frames moderately off target
// [R10] loop steers average hot-region luminance toward the target field
// [R11] sensor select picks the nominal pulse positions
// [R12] locked eeprom ignores write requests and keeps its contents
//
// Decided for this implementation: the AHB-Lite slave port.
module camera_config_register_bank #(
  parameter int BAR_SHIFT = 6
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // eeprom write gate
  input wire logic ee_wr_req,
  output logic ee_wr_grant,
  output logic ee_unlocked,
  // sensor video in and out
  input wire logic pix_valid,
  input wire logic line_start,
  input wire logic [7:0] pix_in,
  output logic pix_out_valid,
  output logic [7:0] pix_out,
  // pulse placement
  output cam_cfg_pkg::pulse_pos_t pulse_pos,
  // exposure loop
  input wire logic frame_done,
  input wire logic [7:0] luma_avg,
  output logic ae_active,
  output logic [7:0] gain,
  // configuration words steering logic outside this bank
  output logic [31:0] dac_offset_word,
  output logic [31:0] optics_word,
  output logic [31:0] status_pin_word,
  output logic [31:0] frontend_word,
  output logic [31:0] motor_word
);

  // ==========================================================
  // bus slave
  // ==========================================================
  cam_cfg_pkg::ahb_req_t req_q;
  logic [31:0] eeprom_q;
  logic [31:0] test_q;
  logic [31:0] sensor_q;
  logic [31:0] sampler_q;
  logic [31:0] ae_q;
  logic [31:0] dac_q;
  logic [31:0] optics_q;
  logic [31:0] statpin_q;
  logic [31:0] frontend_q;
  logic [31:0] motor_q;
  logic unlocked_q;
  logic [31:0] status_word;
  logic wr_en;
  logic hit;

  // zero wait states; single word transfers always answer okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hit = (haddr[31:12] == cam_cfg_pkg::BASE_PAGE); // R01
  assign wr_en = req_q.valid && req_q.write;

  // capture the address phase; offsets outside the page are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_q <= '0;
    end
    else if (hready)
    begin
      req_q.valid <= hsel && htrans[1] && hit; // R01
      req_q.write <= hwrite;
      req_q.ofs <= {haddr[11:2], 2'b00};
    end
  end

  // register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eeprom_q <= cam_cfg_pkg::RST_ZERO;
      test_q <= cam_cfg_pkg::RST_ZERO;
      sensor_q <= cam_cfg_pkg::RST_ZERO;
      sampler_q <= cam_cfg_pkg::RST_ZERO;
      ae_q <= cam_cfg_pkg::RST_AE;
      dac_q <= cam_cfg_pkg::RST_ZERO;
      optics_q <= cam_cfg_pkg::RST_ZERO;
      statpin_q <= cam_cfg_pkg::RST_ZERO;
      frontend_q <= cam_cfg_pkg::RST_FRONTEND;
      motor_q <= cam_cfg_pkg::RST_ZERO;
    end
    else if (wr_en)
    begin
      case (req_q.ofs)
        cam_cfg_pkg::OFS_EEPROM: eeprom_q <= hwdata;
        cam_cfg_pkg::OFS_TEST: test_q <= hwdata & cam_cfg_pkg::MASK_TEST;
        cam_cfg_pkg::OFS_SENSOR:
          sensor_q <= hwdata & cam_cfg_pkg::MASK_SENSOR; // R04
        cam_cfg_pkg::OFS_SAMPLER:
          sampler_q <= hwdata & cam_cfg_pkg::MASK_SAMPLER; // R05
        cam_cfg_pkg::OFS_AE: ae_q <= hwdata;
        cam_cfg_pkg::OFS_DAC: dac_q <= hwdata;
        cam_cfg_pkg::OFS_OPTICS: optics_q <= hwdata;
        cam_cfg_pkg::OFS_STATPIN: statpin_q <= hwdata;
        cam_cfg_pkg::OFS_FRONTEND: frontend_q <= hwdata;
        cam_cfg_pkg::OFS_MOTOR: motor_q <= hwdata;
        default: ;
      endcase
    end
  end

  // the full word must match; any other value relocks at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unlocked_q <= 1'b0;
    end
    else if (wr_en && req_q.ofs == cam_cfg_pkg::OFS_EEPROM)
    begin
      unlocked_q <= (hwdata == cam_cfg_pkg::UNLOCK_MAGIC); // R02
    end
  end

  // read mux over flops; unmapped offsets read zero
  always_comb
  begin
    hrdata = 32'h00000000;
    if (req_q.valid && !req_q.write)
    begin
      case (req_q.ofs)
        cam_cfg_pkg::OFS_EEPROM: hrdata = eeprom_q;
        cam_cfg_pkg::OFS_TEST: hrdata = test_q;
        cam_cfg_pkg::OFS_SENSOR: hrdata = sensor_q;
        cam_cfg_pkg::OFS_SAMPLER: hrdata = sampler_q;
        cam_cfg_pkg::OFS_AE: hrdata = ae_q;
        cam_cfg_pkg::OFS_DAC: hrdata = dac_q;
        cam_cfg_pkg::OFS_OPTICS: hrdata = optics_q;
        cam_cfg_pkg::OFS_STATPIN: hrdata = statpin_q;
        cam_cfg_pkg::OFS_FRONTEND: hrdata = frontend_q;
        cam_cfg_pkg::OFS_MOTOR: hrdata = motor_q;
        cam_cfg_pkg::OFS_STATUS: hrdata = status_word;
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  assign dac_offset_word = dac_q;
  assign optics_word = optics_q;
  assign status_pin_word = statpin_q;
  assign frontend_word = frontend_q;
  assign motor_word = motor_q;

  // ==========================================================
  // eeprom write gate
  // ==========================================================
  // requests while locked are simply not granted, so nothing is stored
  assign ee_wr_grant = ee_wr_req && unlocked_q; // R12
  assign ee_unlocked = unlocked_q; // R02

  // ==========================================================
  // pulse placement
  // ==========================================================
  logic [2:0] sensor_sel;
  logic [1:0] sel_idx;
  logic [5:0] delay [6];
  logic [6:0] pos [6];

  assign sensor_sel = frontend_q[cam_cfg_pkg::SENSOR_SEL_LSB +: 3];
  // unlisted select codes fall back to the first sensor type
  assign sel_idx = (sensor_sel > 3'h2) ? 2'h0 : sensor_sel[1:0]; // R11
  assign delay[0] = sensor_q[cam_cfg_pkg::HORIZ_LSB +: cam_cfg_pkg::POS_W];
  assign delay[1] = sensor_q[cam_cfg_pkg::RGATE_LSB +: cam_cfg_pkg::POS_W];
  assign delay[2] = sensor_q[cam_cfg_pkg::SGATE_LSB +: cam_cfg_pkg::POS_W];
  assign delay[3] = sampler_q[cam_cfg_pkg::CONV_LSB +: cam_cfg_pkg::POS_W];
  assign delay[4] = sampler_q[cam_cfg_pkg::VSMP_LSB +: cam_cfg_pkg::POS_W];
  assign delay[5] = sampler_q[cam_cfg_pkg::RSMP_LSB +: cam_cfg_pkg::POS_W];

  // position = nominal for the sensor plus the programmed delay
  for (genvar i = 0; i < 6; i++)
  begin : g_pos
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        pos[i] <= 7'h00;
      end
      else
      begin
        pos[i] <= {1'b0, cam_cfg_pkg::NOMINAL[sel_idx][i]}
          + {1'b0, delay[i]}; // R04 R05 R11
      end
    end
  end

  assign pulse_pos = {pos[0], pos[1], pos[2], pos[3], pos[4], pos[5]};

  // ==========================================================
  // colour bar generator
  // ==========================================================
  logic [9:0] pix_cnt_q;
  logic [2:0] bar_idx;

  assign bar_idx = pix_cnt_q[BAR_SHIFT +: 3];

  // pixel position along the line, restarted by each line start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pix_cnt_q <= 10'h000;
    end
    else if (line_start)
    begin
      pix_cnt_q <= 10'h000;
    end
    else if (pix_valid)
    begin
      pix_cnt_q <= pix_cnt_q + 10'h001;
    end
  end

  // the pattern keeps the sensor's pixel timing, only data is swapped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pix_out <= 8'h00;
      pix_out_valid <= 1'b0;
    end
    else
    begin
      pix_out_valid <= pix_valid;
      if (test_q[cam_cfg_pkg::TEST_EN_BIT])
        pix_out <= cam_cfg_pkg::BAR_LEVEL[bar_idx]; // R03
      else
        pix_out <= pix_in;
    end
  end

  // ==========================================================
  // auto exposure loop
  // ==========================================================
  cam_cfg_pkg::ae_cfg_t ae_cfg;
  cam_cfg_pkg::ae_state_t ae_state_q;
  logic [7:0] settle_cnt_q;
  logic [7:0] gain_q;
  logic [7:0] err;
  logic [7:0] step;
  logic [8:0] up;
  logic [8:0] dn;
  logic [7:0] gain_d;

  assign ae_cfg = cam_cfg_pkg::ae_cfg_t'(ae_q);

  // settle frames counted from reset before the loop may act
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ae_state_q <= cam_cfg_pkg::AE_SETTLE;
      settle_cnt_q <= 8'h00;
    end
    else
    begin
      case (ae_state_q)
        cam_cfg_pkg::AE_SETTLE:
        begin
          if (settle_cnt_q >= ae_cfg.settle)
            ae_state_q <= cam_cfg_pkg::AE_RUN; // R06
          else if (frame_done)
            settle_cnt_q <= settle_cnt_q + 8'h01; // R06
        end
        cam_cfg_pkg::AE_RUN: ae_state_q <= cam_cfg_pkg::AE_RUN;
        default: ae_state_q <= cam_cfg_pkg::AE_SETTLE;
      endcase
    end
  end

  // step size picked by how far this frame is from target
  always_comb
  begin
    err = (luma_avg > ae_cfg.luma_target) ?
      luma_avg - ae_cfg.luma_target : ae_cfg.luma_target - luma_avg;
    if (err > cam_cfg_pkg::FAR_ERR)
      step = {3'b000, ae_cfg.fast_step}; // R08
    else if (err > cam_cfg_pkg::MOD_ERR)
      step = {5'b00000, ae_cfg.mod_step}; // R09
    else
      step = 8'h00;
    up = {1'b0, gain_q} + {1'b0, step};
    dn = {1'b0, gain_q} - {1'b0, step};
    // dark frames raise gain, bright frames lower it
    if (luma_avg < ae_cfg.luma_target)
      gain_d = up[8] ? 8'hFF : up[7:0]; // R10
    else
      gain_d = dn[8] ? 8'h00 : dn[7:0]; // R10
    // never below the saturation floor
    if (gain_d < ae_cfg.gain_floor)
      gain_d = ae_cfg.gain_floor; // R07
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gain_q <= 8'h00;
    end
    else if (ae_state_q == cam_cfg_pkg::AE_RUN && frame_done)
    begin
      gain_q <= gain_d; // R10
    end
  end

  assign ae_active = (ae_state_q == cam_cfg_pkg::AE_RUN);
  assign gain = gain_q;
  assign status_word = {unlocked_q, ae_active, 6'h00, settle_cnt_q,
                        gain_q, 8'h00};

endmodule

/* test/camera_config_register_bank_props.sv */
module camera_config_register_bank_props (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // side ports
  input wire logic ee_wr_req,
  input wire logic ee_wr_grant,
  input wire logic ee_unlocked,
  input wire logic pix_valid,
  input wire logic pix_out_valid,
  input wire logic frame_done,
  input wire logic ae_active,
  input wire logic [7:0] gain
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // data phase trackers
  logic take, mapped, ee_q, bad_q;
  assign take = hsel && htrans[1] && hready;
  assign mapped = haddr[31:12] == cam_cfg_pkg::BASE_PAGE
    && haddr[11:2] >= 10'h3C0 && haddr[11:2] <= 10'h3CA;
  // registered so each flag lines up with its data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ee_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else
    begin
      ee_q <= take && hwrite && mapped && haddr[11:2] == 10'h3C0;
      bad_q <= take && !hwrite && !mapped;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_magic_wr;
    ee_q && hwdata == cam_cfg_pkg::UNLOCK_MAGIC;
  endsequence
  sequence s_other_wr;
    ee_q && hwdata != cam_cfg_pkg::UNLOCK_MAGIC;
  endsequence
  sequence s_lock_moved;
    $changed(ee_unlocked);
  endsequence
  AST_ZERO_WAIT: assert property (hreadyout && !hresp)
    else $error("slave waited or erred");
  AST_UNMAPPED_READ: assert property (bad_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UNLOCK: assert property (s_magic_wr |=> ee_unlocked)
    else $error("magic word did not unlock");
  AST_LOCK: assert property (s_other_wr |=> !ee_unlocked)
    else $error("other word did not lock");
  AST_LOCK_CAUSE: assert property (s_lock_moved |-> $past(ee_q))
    else $error("lock state moved without a write");
  AST_GRANT: assert property (ee_wr_grant == (ee_wr_req && ee_unlocked))
    else $error("grant wrong for lock state");
  AST_PIX_LAT: assert property (pix_out_valid == $past(pix_valid))
    else $error("pixel latency wrong");
  AST_GAIN_FRAME: assert property ($changed(gain) |-> $past(frame_done))
    else $error("gain moved outside a frame");
  AST_AE_HOLD: assert property (ae_active |=> ae_active)
    else $error("exposure loop dropped out");
endmodule

bind camera_config_register_bank camera_config_register_bank_props
  camera_config_register_bank_props_inst (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .ee_wr_req, .ee_wr_grant, .ee_unlocked, .pix_valid, .pix_out_valid,
  .frame_done, .ae_active, .gain);

/* test/camera_config_register_bank_test.sv */
module test_camera_config_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, hresp, ee_wr_grant, ee_unlocked, pix_out_valid;
  logic ae_active, ee_wr_req = 1'b0, pix_valid = 1'b0;
  logic line_start = 1'b0, frame_done = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] dac_w, optics_w, statpin_w, fe_w, motor_w;
  logic [7:0] pix_in = 8'h0, luma_avg = 8'h0, pix_out, gain;
  cam_cfg_pkg::pulse_pos_t pulse_pos;
  int n_fail = 0, comparisons = 0, cycles = 0, k;
  camera_config_register_bank camera_config_register_bank_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .ee_wr_req, .ee_wr_grant, .ee_unlocked, .pix_valid, .line_start,
    .pix_in, .pix_out_valid, .pix_out, .pulse_pos, .frame_done,
    .luma_avg, .ae_active, .gain, .dac_offset_word(dac_w),
    .optics_word(optics_w), .status_pin_word(statpin_w),
    .frontend_word(fe_w), .motor_word(motor_w));
  always #2 hclk = ~hclk;
  // =====
  // a hang ends here instead of running forever
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // single transfer; answers taken as they stand at the closing edge
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
    logic r;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end while (!r);
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (!r);
  endtask
  function automatic logic [31:0] at(logic [11:0] o);
    return {cam_cfg_pkg::BASE_PAGE, o};
  endfunction
  task automatic rdchk(string n, logic [11:0] o, logic [31:0] e);
    xfer(1'b0, at(o), 32'h0);
    check(n, e, rd);
  endtask
  task automatic pix(logic [7:0] e);
    pix_valid <= 1'b1;
    pix_in <= 8'h55;
    @(posedge hclk);
    pix_valid <= 1'b0;
    @(negedge hclk);
    check("pix_out", 32'(e), 32'(pix_out));
    @(posedge hclk);
  endtask
  task automatic frame(logic [7:0] l, logic [7:0] e);
    frame_done <= 1'b1;
    luma_avg <= l;
    @(posedge hclk);
    frame_done <= 1'b0;
    @(negedge hclk);
    check("gain", 32'(e), 32'(gain));
    @(posedge hclk);
  endtask
  // =====
  // main sequence
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("unlock", cam_cfg_pkg::OFS_EEPROM, 32'h0);
    rdchk("ae", cam_cfg_pkg::OFS_AE, cam_cfg_pkg::RST_AE);
    rdchk("fe", cam_cfg_pkg::OFS_FRONTEND, 32'h00610000);
    // the loop holds off for the settle field's frame count
    check("ae_active", 32'h0, 32'(ae_active));
    frame(8'h00, 8'h00);
    check("ae_active", 32'h0, 32'(ae_active));
    frame(8'h00, 8'h00);
    @(negedge hclk);
    check("ae_active", 32'h1, 32'(ae_active));
    @(posedge hclk);
    xfer(1'b1, at(cam_cfg_pkg::OFS_SENSOR), 32'hFFFFFFFF);
    rdchk("sensor", cam_cfg_pkg::OFS_SENSOR, 32'h003F3F3F);
    xfer(1'b1, at(cam_cfg_pkg::OFS_SAMPLER), 32'hFFFFFFFF);
    rdchk("sampler", cam_cfg_pkg::OFS_SAMPLER, 32'h3F003F3F);
    // select 3 has no table row and falls back to sensor 0
    for (int s = 0; s < 4; s++)
    begin
      k = (s > 2) ? 0 : s;
      xfer(1'b1, at(cam_cfg_pkg::OFS_FRONTEND), 32'h00610000 | (s << 17));
      rdchk("fe", cam_cfg_pkg::OFS_FRONTEND, 32'h00610000 | (s << 17));
      check("horiz", 32'(cam_cfg_pkg::NOMINAL[k][0]) + 32'h3F,
        32'(pulse_pos.horiz_phase_two_pos));
      check("shift_gate", 32'(cam_cfg_pkg::NOMINAL[k][2]) + 32'h3F,
        32'(pulse_pos.shift_gate_phase_one_pos));
      check("ref_sample", 32'(cam_cfg_pkg::NOMINAL[k][5]) + 32'h3F,
        32'(pulse_pos.reference_sample_pos));
    end
    xfer(1'b1, at(cam_cfg_pkg::OFS_SENSOR), 32'h0);
    xfer(1'b1, at(cam_cfg_pkg::OFS_SAMPLER), 32'h0);
    // positions are registered, so give the last write an edge to land
    repeat (2) @(posedge hclk);
    check("reset_gate", 32'(cam_cfg_pkg::NOMINAL[0][1]),
      32'(pulse_pos.reset_gate_pos));
    check("conv_clk", 32'(cam_cfg_pkg::NOMINAL[0][3]),
      32'(pulse_pos.conv_clk_pos));
    check("video_sample", 32'(cam_cfg_pkg::NOMINAL[0][4]),
      32'(pulse_pos.video_sample_pos));
    xfer(1'b1, at(12'hF2C), 32'hFFFFFFFF);
    rdchk("hole", 12'hF2C, 32'h0);
    xfer(1'b1, 32'h00000F10, 32'h0);
    rdchk("ae", cam_cfg_pkg::OFS_AE, cam_cfg_pkg::RST_AE);
    xfer(1'b0, 32'h00000F10, 32'h0);
    check("off_page", 32'h0, rd);
    // plain storage words, seen on the bus and on their outputs
    xfer(1'b1, at(cam_cfg_pkg::OFS_DAC), 32'hA5A5A5A5);
    xfer(1'b1, at(cam_cfg_pkg::OFS_OPTICS), 32'h5A5A5A5A);
    xfer(1'b1, at(cam_cfg_pkg::OFS_STATPIN), 32'h0F0F0F0F);
    xfer(1'b1, at(cam_cfg_pkg::OFS_MOTOR), 32'hF0F0F0F0);
    rdchk("dac", cam_cfg_pkg::OFS_DAC, 32'hA5A5A5A5);
    rdchk("optics", cam_cfg_pkg::OFS_OPTICS, 32'h5A5A5A5A);
    rdchk("statpin", cam_cfg_pkg::OFS_STATPIN, 32'h0F0F0F0F);
    rdchk("motor", cam_cfg_pkg::OFS_MOTOR, 32'hF0F0F0F0);
    check("dac_word", 32'hA5A5A5A5, dac_w);
    check("optics_word", 32'h5A5A5A5A, optics_w);
    check("statpin_word", 32'h0F0F0F0F, statpin_w);
    check("motor_word", 32'hF0F0F0F0, motor_w);
    check("fe_word", 32'h00670000, fe_w);
    ee_wr_req <= 1'b1;
    @(negedge hclk);
    check("grant", 32'h0, 32'(ee_wr_grant));
    // bus requests only start just after a rising edge
    @(posedge hclk);
    xfer(1'b1, at(cam_cfg_pkg::OFS_EEPROM), cam_cfg_pkg::UNLOCK_MAGIC);
    @(negedge hclk);
    check("grant", 32'h1, 32'(ee_wr_grant));
    @(posedge hclk);
    xfer(1'b1, at(cam_cfg_pkg::OFS_EEPROM), 32'h12345679);
    @(negedge hclk);
    check("grant", 32'h0, 32'(ee_wr_grant));
    @(posedge hclk);
    ee_wr_req <= 1'b0;
    xfer(1'b1, at(cam_cfg_pkg::OFS_TEST), 32'h80000000);
    line_start <= 1'b1;
    @(posedge hclk);
    line_start <= 1'b0;
    for (int i = 0; i < 65; i++)
      pix(cam_cfg_pkg::BAR_LEVEL[i >> 6]);
    xfer(1'b1, at(cam_cfg_pkg::OFS_TEST), 32'h0);
    pix(8'h55);
    frame(8'h00, 8'h13);
    frame(8'h70, 8'h15);
    frame(8'h7C, 8'h15);
    frame(8'hFF, 8'h02);
    frame(8'hFF, 8'h00);
    xfer(1'b1, at(cam_cfg_pkg::OFS_AE), 32'h00409A80);
    frame(8'h80, 8'h40);
    // locked, loop running, two settle frames seen, gain at the floor
    rdchk("status", cam_cfg_pkg::OFS_STATUS, 32'h40024000);
    conclude();
  end
endmodule
